// ===== e1_rx_nat_map.vh
// register offsets, field positions, reset values and frame constants
`ifndef E1_RX_NAT_MAP_VH
`define E1_RX_NAT_MAP_VH

// register offsets within one channel
`define OFS_RX_LINK_ENABLE 12'h10c
`define OFS_SS7_SUF1 12'h138
`define OFS_SS7_SUF2 12'h139
`define OFS_SS7_SUF3 12'h13a
`define OFS_NAT_BIT4 12'h13b
`define OFS_NAT_BIT5 12'h13c
`define OFS_NAT_BIT6 12'h13d
`define OFS_NAT_BIT7 12'h13e
`define OFS_NAT_BIT8 12'h13f
`define OFS_MF_COUNT 12'h140

// field positions in the receive link enable register
`define POS_BIT4_LINK_ENABLE 0
`define POS_BIT5_LINK_ENABLE 1
`define POS_BIT6_LINK_ENABLE 2
`define POS_BIT7_LINK_ENABLE 3
`define POS_BIT8_LINK_ENABLE 4

// reset values
`define RST_RX_LINK_ENABLE 5'h00
`define RST_SS7_SUF 8'h00
`define RST_NAT_BIT 8'h00
`define RST_MF_COUNT 8'h00

// multiframe layout: frame index 0..15, national bits in odd indices
`define MF_LAST_FRAME 4'hf
`define MF_FIRST_FRAME 4'h0
`define MF_ALL_SLOTS 8'hff

`endif

// ===== nat_bit_collector.v
// gathers the national bits of one multiframe and flags its completion
`timescale 1ns/1ps
`default_nettype none
`include "e1_rx_nat_map.vh"

module nat_bit_collector (
    // clock and synchronised reset
    input wire clk_in,
    input wire rst_n_in,
    // per-frame national bits from the receive framer
    input wire frame_stb_in,
    input wire [3:0] frame_idx_in,
    input wire [4:0] sa_bits_in,
    // collected multiframe, Sa4 in [7:0] up to Sa8 in [39:32]
    output reg [39:0] mf_bits_out,
    output reg mf_done_out
);

    reg [39:0] work_q;
    reg [7:0] slots_q;
    reg [2:0] pos;
    integer k;

    // odd frame index n carries its bit at position 7 - n/2
    always @*
    begin
        pos = 3'h7 - frame_idx_in[3:1];
    end

    // store each odd frame in its slot; hand the whole word over after the last frame if no slot is missing
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            work_q <= 40'h0000000000;
            slots_q <= 8'h00;
            mf_bits_out <= 40'h0000000000;
            mf_done_out <= 1'b0;
        end
        else
        begin
            mf_done_out <= 1'b0;
            if (frame_stb_in)
            begin
                if (frame_idx_in == `MF_FIRST_FRAME)
                begin
                    slots_q <= 8'h00; // a new multiframe starts clean
                end
                else if (frame_idx_in[0])
                begin
                    for (k = 0; k < 5; k = k + 1)
                    begin
                        work_q[k*8 + pos] <= sa_bits_in[k];
                    end
                    if (frame_idx_in == `MF_LAST_FRAME &&
                        (slots_q | 8'h01) == `MF_ALL_SLOTS)
                    begin
                        mf_done_out <= 1'b1;
                        // the closing frame's bit lands in bit 0 of each byte
                        mf_bits_out <= {work_q[39:33], sa_bits_in[4],
                                        work_q[31:25], sa_bits_in[3],
                                        work_q[23:17], sa_bits_in[2],
                                        work_q[15:9], sa_bits_in[1],
                                        work_q[7:1], sa_bits_in[0]};
                        slots_q <= 8'h00;
                    end
                    else
                    begin
                        slots_q[pos] <= 1'b1;
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== e1_rx_national_bit_capture.v
// receive national bit capture registers and signalling-unit field registers
//
// Contract
// - five 8-bit read-only registers hold Sa4..Sa8 bits of the latest multiframe received while that position's link enable was set.
// - captures refresh only after a whole multiframe has been received.
// - frame 1 bit goes to bit 7, frame 3 to bit 6, down to bit 0.
// - three read/write 8-bit signalling-unit field registers at consecutive offsets.
// - Sa5 capture at 0x13c, Sa7 capture at 0x13e, read-only, reset zero.
`timescale 1ns/1ps
`default_nettype none
`include "e1_rx_nat_map.vh"

module e1_rx_national_bit_capture (
    // clock and reset
    input wire core_clk_in,
    input wire arst_n_in,
    // register port
    input wire [11:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    // receive framer national bit stream
    input wire rx_frame_stb_in,
    input wire [3:0] rx_frame_idx_in,
    input wire [4:0] rx_sa_bits_in,
    // capture refresh indication
    output reg rx_mf_update_out
);

    reg rst_meta_q;
    reg rst_sync_q;
    reg [4:0] rx_link_enable_q;
    reg [7:0] signal_unit_field_q [0:2];
    reg [7:0] rx_nat_bit_q [0:4];
    reg [7:0] mf_count_q;
    wire [39:0] mf_bits;
    wire mf_done;
    integer i;

    // per-position receive link enables
    wire rx_nat_bit4_link_enable;
    wire rx_nat_bit5_link_enable;
    wire rx_nat_bit6_link_enable;
    wire rx_nat_bit7_link_enable;
    wire rx_nat_bit8_link_enable;
    // per-position bits of the last complete multiframe
    wire [7:0] rx_nat_bit4_value;
    wire [7:0] rx_nat_bit5_value;
    wire [7:0] rx_nat_bit6_value;
    wire [7:0] rx_nat_bit7_value;
    wire [7:0] rx_nat_bit8_value;

    // index of a national bit capture register, 7 when not one
    function [2:0] nat_index;
        input [11:0] addr;
        begin
            case (addr)
                `OFS_NAT_BIT4: nat_index = 3'h0;
                `OFS_NAT_BIT5: nat_index = 3'h1;
                `OFS_NAT_BIT6: nat_index = 3'h2;
                `OFS_NAT_BIT7: nat_index = 3'h3;
                `OFS_NAT_BIT8: nat_index = 3'h4;
                default: nat_index = 3'h7;
            endcase
        end
    endfunction

    // index of a signalling-unit field register, 3 when not one
    function [1:0] suf_index;
        input [11:0] addr;
        begin
            case (addr)
                `OFS_SS7_SUF1: suf_index = 2'h0;
                `OFS_SS7_SUF2: suf_index = 2'h1;
                `OFS_SS7_SUF3: suf_index = 2'h2;
                default: suf_index = 2'h3;
            endcase
        end
    endfunction

    // reset release through two flip-flops
    always @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // multiframe collection of the received national bits
    nat_bit_collector u_collector (
        .clk_in(core_clk_in),
        .rst_n_in(rst_sync_q),
        .frame_stb_in(rx_frame_stb_in),
        .frame_idx_in(rx_frame_idx_in),
        .sa_bits_in(rx_sa_bits_in),
        .mf_bits_out(mf_bits),
        .mf_done_out(mf_done)
    );

    // link enable bits split per national bit position
    assign rx_nat_bit4_link_enable = rx_link_enable_q[`POS_BIT4_LINK_ENABLE];
    assign rx_nat_bit5_link_enable = rx_link_enable_q[`POS_BIT5_LINK_ENABLE];
    assign rx_nat_bit6_link_enable = rx_link_enable_q[`POS_BIT6_LINK_ENABLE];
    assign rx_nat_bit7_link_enable = rx_link_enable_q[`POS_BIT7_LINK_ENABLE];
    assign rx_nat_bit8_link_enable = rx_link_enable_q[`POS_BIT8_LINK_ENABLE];

    // collected multiframe split per position, frame 1 bit on top
    assign rx_nat_bit4_value = mf_bits[7:0];
    assign rx_nat_bit5_value = mf_bits[15:8];
    assign rx_nat_bit6_value = mf_bits[23:16];
    assign rx_nat_bit7_value = mf_bits[31:24];
    assign rx_nat_bit8_value = mf_bits[39:32];

    // software writable registers
    always @(posedge core_clk_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            rx_link_enable_q <= `RST_RX_LINK_ENABLE;
            for (i = 0; i < 3; i = i + 1)
            begin
                signal_unit_field_q[i] <= `RST_SS7_SUF;
            end
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == `OFS_RX_LINK_ENABLE)
            begin
                rx_link_enable_q <= reg_wdata_in[4:0];
            end
            if (suf_index(reg_addr_in) != 2'h3)
            begin
                signal_unit_field_q[suf_index(reg_addr_in)] <= reg_wdata_in;
            end
        end
    end

    // capture update once per complete multiframe, per enabled position
    always @(posedge core_clk_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            for (i = 0; i < 5; i = i + 1)
            begin
                rx_nat_bit_q[i] <= `RST_NAT_BIT;
            end
            mf_count_q <= `RST_MF_COUNT;
            rx_mf_update_out <= 1'b0;
        end
        else
        begin
            rx_mf_update_out <= mf_done;
            if (mf_done)
            begin
                mf_count_q <= mf_count_q + 8'h01;
                // a disabled position keeps its previous capture
                if (rx_nat_bit4_link_enable)
                begin
                    rx_nat_bit_q[0] <= rx_nat_bit4_value;
                end
                if (rx_nat_bit5_link_enable)
                begin
                    rx_nat_bit_q[1] <= rx_nat_bit5_value;
                end
                if (rx_nat_bit6_link_enable)
                begin
                    rx_nat_bit_q[2] <= rx_nat_bit6_value;
                end
                if (rx_nat_bit7_link_enable)
                begin
                    rx_nat_bit_q[3] <= rx_nat_bit7_value;
                end
                if (rx_nat_bit8_link_enable)
                begin
                    rx_nat_bit_q[4] <= rx_nat_bit8_value;
                end
            end
        end
    end

    // read data for one cycle after the strobe; reads change no state
    always @(posedge core_clk_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            reg_rdata_out <= 8'h00;
        end
        else if (!reg_rd_in)
        begin
            reg_rdata_out <= 8'h00;
        end
        else if (nat_index(reg_addr_in) != 3'h7)
        begin
            reg_rdata_out <= rx_nat_bit_q[nat_index(reg_addr_in)];
        end
        else if (suf_index(reg_addr_in) != 2'h3)
        begin
            reg_rdata_out <= signal_unit_field_q[suf_index(reg_addr_in)];
        end
        else if (reg_addr_in == `OFS_RX_LINK_ENABLE)
        begin
            reg_rdata_out <= {3'h0, rx_link_enable_q};
        end
        else if (reg_addr_in == `OFS_MF_COUNT)
        begin
            reg_rdata_out <= mf_count_q;
        end
        else
        begin
            reg_rdata_out <= 8'h00; // unmapped reads zero
        end
    end

endmodule
`default_nettype wire

// ===== e1_rx_nat_props.sv
// assertion checker for the national bit capture block
`timescale 1ns/1ps
`default_nettype none
module e1_rx_nat_props (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // register port
    input wire logic [11:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // frame link
    input wire logic rx_frame_stb_in,
    input wire logic [3:0] rx_frame_idx_in,
    input wire logic [4:0] rx_sa_bits_in,
    input wire logic rx_mf_update_out
);
    logic upd_seen_q;
    logic [4:0] ever_en_q;
    wire logic cap_rd = reg_rd_in && reg_addr_in >= 12'h13b && reg_addr_in <= 12'h13f;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    // remember any refresh, and every position ever enabled, since reset
    always_ff @(posedge core_clk_in or negedge arst_n_in)
        if (!arst_n_in) {upd_seen_q, ever_en_q} <= 6'h00;
        else {upd_seen_q, ever_en_q} <= {upd_seen_q | rx_mf_update_out,
            ever_en_q | (reg_wr_in && reg_addr_in == 12'h10c ? reg_wdata_in[4:0] : 5'h00)};
    sequence s_rd_sa5;
        reg_rd_in && reg_addr_in == 12'h13c;
    endsequence
    sequence s_wr_sf1;
        reg_wr_in && reg_addr_in == 12'h138;
    endsequence
    sequence s_rd_sf1;
        reg_rd_in && reg_addr_in == 12'h138;
    endsequence
    // write, read back at once, data shows the cycle after the read
    property p_sf_rdback;
        s_wr_sf1 ##1 s_rd_sf1 |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    a_rd_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside a read slot");
    a_upd_after_last: assert property (rx_mf_update_out |->
        $past(rx_frame_stb_in, 2) && $past(rx_frame_idx_in, 2) == 4'hf)
        else $error("refresh without a closing frame");
    a_upd_gap: assert property (rx_mf_update_out |=> !rx_mf_update_out [*8])
        else $error("refreshes closer than a multiframe");
    a_sf_rdback: assert property (p_sf_rdback)
        else $error("field register lost its write");
    a_cap_reset: assert property (cap_rd && !upd_seen_q && !rx_mf_update_out |=>
        reg_rdata_out == 8'h00) else $error("capture not zero before refresh");
    a_cap_gated: assert property (cap_rd && !ever_en_q[reg_addr_in[2:0] - 3'h3] |=>
        reg_rdata_out == 8'h00) else $error("capture moved while disabled");
    a_cap_stable: assert property (s_rd_sa5 ##1 (s_rd_sa5 and !rx_mf_update_out) |=>
        $stable(reg_rdata_out)) else $error("capture changed by a read");
endmodule
bind e1_rx_national_bit_capture e1_rx_nat_props u_props (.*);
`default_nettype wire

// ===== e1_framer_model.sv
// behavioural receive framer that plays multiframes
`timescale 1ns/1ps
`default_nettype none
module e1_framer_model (
    // clock
    input wire logic clk_in,
    // frame link
    output logic stb_out,
    output logic [3:0] idx_out,
    output logic [4:0] sa_out
);
    initial {stb_out, idx_out, sa_out} = '0;
    // one multiframe, Sa4 byte in [7:0] up to Sa8 in [39:32]; skip drops frame 7
    task automatic send(input logic [39:0] caps, input bit skip, input bit slow);
        for (int f = 0; f < 16; f++)
        begin
            @(posedge clk_in);
            stb_out <= !(skip && f == 7);
            idx_out <= f[3:0];
            for (int k = 0; k < 5; k++)
                sa_out[k] <= f[0] ? caps[8 * k + 7 - f / 2] : ~sa_out[k];
            @(posedge clk_in);
            stb_out <= 1'b0;
            idx_out <= ~idx_out; // stale lines never hold the last value
            sa_out <= ~sa_out;
            if (slow) repeat (2) @(posedge clk_in);
        end
    endtask
endmodule
`default_nettype wire

// ===== tb_e1_rx_national_bit_capture.sv
// self-checking bench for the national bit capture block
`timescale 1ns/1ps
`default_nettype none
module tb_e1_rx_national_bit_capture;
    logic core_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [11:0] reg_addr_in = '0;
    logic [7:0] reg_wdata_in = '0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic rx_frame_stb_in;
    logic [3:0] rx_frame_idx_in;
    logic [4:0] rx_sa_bits_in;
    logic rx_mf_update_out;
    int miscompares = 0;
    int n_compared = 0;
    int seed = 32'h34e1ae39;
    int n_upd = 0;
    int n_mf = 0;
    logic [7:0] cap [5] = '{default: 8'h00};
    logic [7:0] sf [3] = '{default: 8'h00};
    logic [39:0] mf;
    logic [4:0] en = 5'h00;
    e1_rx_national_bit_capture dut (.*);
    e1_framer_model fr (.clk_in(core_clk_in), .stb_out(rx_frame_stb_in),
        .idx_out(rx_frame_idx_in), .sa_out(rx_sa_bits_in));
    // clock and refresh pulse counter
    initial forever #10 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) if (rx_mf_update_out === 1'b1) n_upd++;
    function automatic logic [7:0] exp_of(input int a);
        if (a >= 'h138 && a <= 'h13a) return sf[a - 'h138];
        if (a >= 'h13b && a <= 'h13f) return cap[a - 'h13b];
        if (a == 'h140) return n_mf[7:0];
        if (a == 'h10c) return {3'h0, en};
        return 8'h00;
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic op(input bit w, input bit r, input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= w;
        reg_rd_in <= r;
        reg_addr_in <= a;
        reg_wdata_in <= d;
    endtask
    task automatic rd(input int a);
        op(0, 1, a[11:0], 8'h00);
        op(0, 0, a[11:0], 8'h00);
        #1 chk($sformatf("reg %h", a[11:0]), exp_of(a), reg_rdata_out);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (4000) @(posedge core_clk_in);
        miscompares++;
        tally_and_finish();
    end
    // main sequence
    initial
    begin
        repeat (8) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        for (int a = 'h138; a <= 'h140; a++) rd(a);
        op(1, 0, 12'h13e, 8'hff);
        op(1, 0, 12'h150, 8'h5a);
        rd('h13e);
        rd('h150);
        $display("defaults done");
        for (int i = 0; i < 3; i++)
        begin
            sf[i] = 8'($random(seed));
            op(1, 0, 12'h138 + i[11:0], sf[i]);
            rd('h138 + i);
        end
        $display("field registers done");
        for (int i = 0; i < 6; i++)
        begin
            en = (i == 0) ? 5'h00 : 5'($random(seed));
            op(1, 0, 12'h10c, {3'h0, en});
            rd('h10c);
            mf = 40'({$random(seed), $random(seed)});
            fr.send(mf, i == 3, i[0]);
            repeat (3) @(posedge core_clk_in);
            if (i != 3) n_mf++;
            for (int k = 0; k < 5; k++)
                if (en[k] && i != 3) cap[k] = mf[8 * k +: 8];
            for (int a = 'h13b; a <= 'h140; a++) rd(a);
            chk("refresh count", n_mf[7:0], n_upd[7:0]);
        end
        $display("multiframes done");
        op(1, 0, 12'h13c, 8'ha5);
        op(0, 1, 12'h13c, 8'h00);
        op(0, 1, 12'h13c, 8'h00);
        #1 chk("first read", cap[1], reg_rdata_out);
        op(0, 0, 12'h000, 8'h00);
        #1 chk("second read", cap[1], reg_rdata_out);
        $display("repeat reads done");
        // mid-run reset brings every register back to its default
        @(posedge core_clk_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        cap = '{default: 8'h00};
        sf = '{default: 8'h00};
        n_mf = 0;
        en = 5'h00;
        for (int a = 'h138; a <= 'h140; a++) rd(a);
        rd('h10c);
        $display("mid-run reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
